// file: logic/mdc_pkg.sv
// motor drive control register bank: shared constants, field positions and types
// assumes a 25 MHz ref_clk and a 6-bit register address from the serial port decoder
package mdc_pkg;

    // register port geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [5:0] OFS_HALL_BRAKE_DIRECTION_CTRL = 6'h09;
    localparam logic [5:0] OFS_SPEED_PULSE_STALL_CTRL = 6'h0A;
    localparam logic [5:0] OFS_PHASE_LEAD_CTRL = 6'h0B;
    localparam logic [5:0] OFS_DELAY_MATCH_CTRL = 6'h0C;

    // values after reset
    localparam logic [7:0] RST_HALL_BRAKE_DIRECTION_CTRL = 8'h01;
    localparam logic [7:0] RST_SPEED_PULSE_STALL_CTRL = 8'h41;
    localparam logic [7:0] RST_PHASE_LEAD_CTRL = 8'h00;
    localparam logic [7:0] RST_DELAY_MATCH_CTRL = 8'h00;

    // writable bits; all others are reserved
    localparam logic [7:0] WMASK_HALL_BRAKE_DIRECTION_CTRL = 8'h1F;
    localparam logic [7:0] WMASK_SPEED_PULSE_STALL_CTRL = 8'hDF;
    localparam logic [7:0] WMASK_PHASE_LEAD_CTRL = 8'h07;
    localparam logic [7:0] WMASK_DELAY_MATCH_CTRL = 8'h1F;

    // field positions, first register
    localparam int POS_HALL_COMPARATOR_HYSTERESIS = 4;
    localparam int POS_BRAKE_STYLE = 3;
    localparam int POS_FREEWHEEL = 2;
    localparam int POS_BRAKE = 1;
    localparam int POS_ROTATION = 0;
    // field positions, second register
    localparam int POS_SPEED_DIV = 6;
    localparam int POS_STALL_RETRY = 4;
    localparam int POS_STALL_DETECT = 2;
    localparam int POS_STALL_RESP = 0;
    // field positions, third and fourth register
    localparam int POS_PHASE_LEAD = 0;
    localparam int POS_DLY_EN = 4;
    localparam int POS_DLY_GOAL = 0;

    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int STALL_DET_MS_0 = 300;
    localparam int STALL_DET_MS_1 = 500;
    localparam int STALL_DET_MS_2 = 1000;
    localparam int STALL_DET_MS_3 = 5000;
    localparam int STALL_RETRY_MS_0 = 500;
    localparam int STALL_RETRY_MS_1 = 5000;
    localparam int DLY_STEP_NS = 200;
    localparam int DLY_STEP_CYC = (DLY_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DLY_CNT_W = 7;

    // stall response codes
    typedef enum logic [1:0] {
        STALL_LATCH = 2'h0,
        STALL_RETRY = 2'h1,
        STALL_REPORT = 2'h2,
        STALL_IGNORE = 2'h3
    } mdc_stall_resp_t;

    // stall supervisor states, gray along idle, count, fault, retry
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_FAULT = 2'b11,
        ST_RETRY = 2'b10
    } mdc_stall_state_t;

    // decoded configuration seen by the drive logic
    typedef struct packed {
        logic hall_comparator_hysteresis;
        logic brake_style_coast;
        logic freewheel_en;
        logic brake_en;
        logic rotation_ccw;
        logic [1:0] speed_pulse_divider;
        logic stall_retry_time;
        logic [1:0] stall_detect_time;
        logic [1:0] stall_fault_response;
        logic [2:0] phase_lead_angle;
        logic delay_match_enable;
        logic [3:0] delay_match_goal;
    } mdc_cfg_t;

    // register read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mdc_rd_t;

endpackage

// file: logic/mdc_delay_match.sv
// one phase of driver delay matching: holds each output transition so that
// the total delay reaches the goal for both current directions
// assumes cmd and sourcing come from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
module mdc_delay_match import mdc_pkg::*; #(
    parameter int SRC_DLY_CYC = 2,
    parameter int SNK_DLY_CYC = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration
    input wire logic enable,
    input wire logic [3:0] goal,
    // phase command
    input wire logic cmd,
    input wire logic sourcing,
    output logic drive_q
);

    typedef struct packed {
        logic target;
        logic pending;
        logic [DLY_CNT_W-1:0] cnt;
        logic drive;
    } mdc_dm_state_t;

    mdc_dm_state_t s_q, s_d;
    logic [DLY_CNT_W-1:0] goal_cyc;
    logic [DLY_CNT_W-1:0] own_cyc;
    logic [DLY_CNT_W-1:0] var_cyc;

    always_comb begin
        // code 0 is no delay, code n is (n+1) steps
        if (goal == 4'h0) begin
            goal_cyc = '0;
        end else begin
            goal_cyc = DLY_CNT_W'((32'(goal) + 32'd1) * 32'(DLY_STEP_CYC));
        end
        own_cyc = sourcing ? DLY_CNT_W'(SRC_DLY_CYC) : DLY_CNT_W'(SNK_DLY_CYC);
        // the variable part never goes negative; a short goal just passes through
        var_cyc = (goal_cyc > own_cyc) ? goal_cyc - own_cyc : '0;
        s_d = s_q;
        if (!enable) begin
            s_d.drive = cmd;
            s_d.target = cmd;
            s_d.pending = 1'b0;
            s_d.cnt = '0;
        end else if (cmd != s_q.target) begin
            // a new edge restarts the wait, so a glitch shorter than the delay is dropped
            s_d.target = cmd;
            s_d.pending = (var_cyc != '0);
            s_d.cnt = var_cyc;
            if (var_cyc == '0) begin
                s_d.drive = cmd;
            end
        end else if (s_q.pending) begin
            if (s_q.cnt <= DLY_CNT_W'(1)) begin
                s_d.pending = 1'b0;
                s_d.cnt = '0;
                s_d.drive = s_q.target;
            end else begin
                s_d.cnt = s_q.cnt - DLY_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign drive_q = s_q.drive;

endmodule
`default_nettype wire

// file: logic/mdc_ctrl_regs.sv
// motor drive control register bank: four configuration registers, the
// speed-pulse divider, the stall supervisor and three phases of delay matching
// assumes the serial port decoder presents single-cycle read and write strobes
// on ref_clk, and that the commutation logic shares that clock
//
// Summary of operation
// - hysteresis bit 4 of first register: clear 5 mV, set 50 mV; resets 0.
// - brake-style bit 3: clear brakes actively, set coasts while brake requested.
// - freewheel bit 2 set enables coast mode; resets 0.
// - brake bit 1 set enables brake mode; resets 0.
// - rotation bit 0: clear clockwise, set anti-clockwise; resets 1.
// - divider bits 7-6 divide commutation frequency by 1, 2, 4, 8; resets 1.
// - retry-time bit 4 selects 500 ms or 5000 ms retry wait.
// - detect field bits 3-2 selects 300, 500, 1000 or 5000 ms stall time.
// - response code 0: stall raises a fault latched until explicitly cleared.
// - response code 1, default: fault clears itself and retries after retry time.
// - response code 2: stall only reported; driving continues.
// - response code 3: stall neither reported nor acted upon.
// - phase-lead bits 2-0 give 0 to 30 degrees advance; resets 0.
// - delay-match enable bit 4 of last register; resets 0.
// - delay-match goal bits 3-0: 0, 0.4 us, then 0.2 us steps to 3.2 us.
// - speed-pulse and stall register resets to 41h.
// - delay matching pads each transition so both current directions hit the goal.
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl_regs import mdc_pkg::*; #(
    parameter int CYC_PER_MS_P = CYC_PER_MS,
    parameter int PHASES = 3,
    parameter int SRC_DLY_CYC = 2,
    parameter int SNK_DLY_CYC = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port from the serial decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // commutation side
    input wire logic comm_level,
    input wire logic stall_seen,
    input wire logic stall_clear,
    input wire logic [PHASES-1:0] phase_cmd,
    input wire logic [PHASES-1:0] phase_sourcing,
    // configuration to the drive logic
    output logic hall_comparator_hysteresis,
    output logic rotation_ccw,
    output logic bridge_brake,
    output logic bridge_coast,
    output logic [2:0] phase_lead_angle,
    // status and outputs
    output logic speed_pulse_output,
    output logic stall_fault,
    output logic drive_inhibit,
    output logic [PHASES-1:0] phase_drive
);

    localparam int TCNT_W = 32;

    typedef struct packed {
        logic [7:0] r_hbd;
        logic [7:0] r_sps;
        logic [7:0] r_pl;
        logic [7:0] r_dm;
        mdc_rd_t rd;
        logic comm_last;
        logic [1:0] pulse_cnt;
        logic pulse;
        mdc_stall_state_t st;
        logic [TCNT_W-1:0] tcnt;
        logic fault;
        logic inhibit;
        logic brake;
        logic coast;
    } mdc_state_t;

    mdc_state_t s_q, s_d;
    mdc_cfg_t cfg;
    logic [TCNT_W-1:0] detect_cyc;
    logic [TCNT_W-1:0] retry_cyc;
    logic comm_rise;
    logic [1:0] half_cnt;
    logic [7:0] rd_val;
    logic clear_now;

    // field decode from the live registers
    always_comb begin
        cfg.hall_comparator_hysteresis = s_q.r_hbd[POS_HALL_COMPARATOR_HYSTERESIS];
        cfg.brake_style_coast = s_q.r_hbd[POS_BRAKE_STYLE];
        cfg.freewheel_en = s_q.r_hbd[POS_FREEWHEEL];
        cfg.brake_en = s_q.r_hbd[POS_BRAKE];
        cfg.rotation_ccw = s_q.r_hbd[POS_ROTATION];
        cfg.speed_pulse_divider = s_q.r_sps[POS_SPEED_DIV +: 2];
        cfg.stall_retry_time = s_q.r_sps[POS_STALL_RETRY];
        cfg.stall_detect_time = s_q.r_sps[POS_STALL_DETECT +: 2];
        cfg.stall_fault_response = s_q.r_sps[POS_STALL_RESP +: 2];
        cfg.phase_lead_angle = s_q.r_pl[POS_PHASE_LEAD +: 3];
        cfg.delay_match_enable = s_q.r_dm[POS_DLY_EN];
        cfg.delay_match_goal = s_q.r_dm[POS_DLY_GOAL +: 4];
    end

    // stall time in cycles; the per-ms count is a parameter so tests can shrink it
    always_comb begin
        case (cfg.stall_detect_time)
            2'h0: begin
                detect_cyc = TCNT_W'(STALL_DET_MS_0 * CYC_PER_MS_P);
            end
            2'h1: begin
                detect_cyc = TCNT_W'(STALL_DET_MS_1 * CYC_PER_MS_P);
            end
            2'h2: begin
                detect_cyc = TCNT_W'(STALL_DET_MS_2 * CYC_PER_MS_P);
            end
            default: begin
                detect_cyc = TCNT_W'(STALL_DET_MS_3 * CYC_PER_MS_P);
            end
        endcase
        if (cfg.stall_retry_time) begin
            retry_cyc = TCNT_W'(STALL_RETRY_MS_1 * CYC_PER_MS_P);
        end else begin
            retry_cyc = TCNT_W'(STALL_RETRY_MS_0 * CYC_PER_MS_P);
        end
    end

    // readback mux; unmapped addresses answer zero
    always_comb begin
        if (reg_addr == OFS_HALL_BRAKE_DIRECTION_CTRL) begin
            rd_val = s_q.r_hbd;
        end else if (reg_addr == OFS_SPEED_PULSE_STALL_CTRL) begin
            rd_val = s_q.r_sps;
        end else if (reg_addr == OFS_PHASE_LEAD_CTRL) begin
            rd_val = s_q.r_pl;
        end else if (reg_addr == OFS_DELAY_MATCH_CTRL) begin
            rd_val = s_q.r_dm;
        end else begin
            rd_val = 8'h00;
        end
    end

    // toggle after half the divided period; code 0 just follows the level
    always_comb begin
        case (cfg.speed_pulse_divider)
            2'h2: begin
                half_cnt = 2'h1;
            end
            2'h3: begin
                half_cnt = 2'h3;
            end
            default: begin
                half_cnt = 2'h0;
            end
        endcase
    end

    assign comm_rise = comm_level && !s_q.comm_last;
    assign clear_now = stall_clear;

    always_comb begin
        s_d = s_q;
        s_d.rd.valid = 1'b0;

        // register writes; the mask keeps reserved bits at zero
        if (reg_wr) begin
            if (reg_addr == OFS_HALL_BRAKE_DIRECTION_CTRL) begin
                s_d.r_hbd = reg_wdata & WMASK_HALL_BRAKE_DIRECTION_CTRL;
            end else if (reg_addr == OFS_SPEED_PULSE_STALL_CTRL) begin
                s_d.r_sps = reg_wdata & WMASK_SPEED_PULSE_STALL_CTRL;
            end else if (reg_addr == OFS_PHASE_LEAD_CTRL) begin
                s_d.r_pl = reg_wdata & WMASK_PHASE_LEAD_CTRL;
            end else if (reg_addr == OFS_DELAY_MATCH_CTRL) begin
                s_d.r_dm = reg_wdata & WMASK_DELAY_MATCH_CTRL;
            end
        end

        // reads answer one cycle later from the pre-write contents
        if (reg_rd) begin
            s_d.rd.valid = 1'b1;
            s_d.rd.data = rd_val & 8'hFF;
        end

        // speed pulse output
        s_d.comm_last = comm_level;
        if (cfg.speed_pulse_divider == 2'h0) begin
            s_d.pulse = comm_level;
            s_d.pulse_cnt = 2'h0;
        end else if (comm_rise) begin
            if (s_q.pulse_cnt >= half_cnt) begin
                s_d.pulse = !s_q.pulse;
                s_d.pulse_cnt = 2'h0;
            end else begin
                s_d.pulse_cnt = s_q.pulse_cnt + 2'h1;
            end
        end

        // bridge mode: freewheel wins, brake obeys the brake-style choice
        s_d.coast = cfg.freewheel_en || (cfg.brake_en && cfg.brake_style_coast);
        s_d.brake = !cfg.freewheel_en && cfg.brake_en && !cfg.brake_style_coast;

        // a report-only flag is cleared here; a new stall in the same cycle wins
        if (clear_now && s_q.st != ST_FAULT && s_q.st != ST_RETRY) begin
            s_d.fault = 1'b0;
        end

        case (s_q.st)
            ST_IDLE: begin
                s_d.tcnt = '0;
                if (stall_seen && cfg.stall_fault_response != STALL_IGNORE) begin
                    s_d.st = ST_COUNT;
                    s_d.tcnt = TCNT_W'(1);
                end
            end
            ST_COUNT: begin
                if (!stall_seen || cfg.stall_fault_response == STALL_IGNORE) begin
                    s_d.st = ST_IDLE;
                    s_d.tcnt = '0;
                end else if (s_q.tcnt >= detect_cyc) begin
                    s_d.tcnt = '0;
                    s_d.fault = 1'b1;
                    case (cfg.stall_fault_response)
                        STALL_LATCH: begin
                            s_d.st = ST_FAULT;
                            s_d.inhibit = 1'b1;
                        end
                        STALL_RETRY: begin
                            s_d.st = ST_RETRY;
                            s_d.inhibit = 1'b1;
                        end
                        default: begin
                            // report only: flag stays, driving goes on
                            s_d.st = ST_IDLE;
                        end
                    endcase
                end else begin
                    s_d.tcnt = s_q.tcnt + TCNT_W'(1);
                end
            end
            ST_FAULT: begin
                // holds until software clears it, whatever the stall input does
                if (clear_now) begin
                    s_d.st = ST_IDLE;
                    s_d.fault = 1'b0;
                    s_d.inhibit = 1'b0;
                end
            end
            ST_RETRY: begin
                if (s_q.tcnt >= retry_cyc) begin
                    s_d.st = ST_IDLE;
                    s_d.tcnt = '0;
                    s_d.fault = 1'b0;
                    s_d.inhibit = 1'b0;
                end else begin
                    s_d.tcnt = s_q.tcnt + TCNT_W'(1);
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.r_hbd <= RST_HALL_BRAKE_DIRECTION_CTRL;
            s_q.r_sps <= RST_SPEED_PULSE_STALL_CTRL;
            s_q.r_pl <= RST_PHASE_LEAD_CTRL;
            s_q.r_dm <= RST_DELAY_MATCH_CTRL;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // one delay matcher per phase
    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi++) begin : g_phase
            mdc_delay_match #(
                .SRC_DLY_CYC(SRC_DLY_CYC),
                .SNK_DLY_CYC(SNK_DLY_CYC)
            ) u_dm (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .enable(cfg.delay_match_enable),
                .goal(cfg.delay_match_goal),
                .cmd(phase_cmd[gi]),
                .sourcing(phase_sourcing[gi]),
                .drive_q(phase_drive[gi])
            );
        end
    endgenerate

    // outputs straight from the state flops
    assign reg_rdata = s_q.rd.data;
    assign reg_rvalid = s_q.rd.valid;
    assign hall_comparator_hysteresis = s_q.r_hbd[POS_HALL_COMPARATOR_HYSTERESIS];
    assign rotation_ccw = s_q.r_hbd[POS_ROTATION];
    assign phase_lead_angle = s_q.r_pl[POS_PHASE_LEAD +: 3];
    assign bridge_brake = s_q.brake;
    assign bridge_coast = s_q.coast;
    assign speed_pulse_output = s_q.pulse;
    assign stall_fault = s_q.fault;
    assign drive_inhibit = s_q.inhibit;

endmodule
`default_nettype wire

// file: verif/mdc_ctrl_regs_chk.sv
// assertions for the motor drive control register bank
// assumes one ref_clk domain; sees only the ports of mdc_ctrl_regs
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl_regs_chk import mdc_pkg::*; #(
    parameter int PHASES = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    // commutation side
    input wire logic comm_level,
    input wire logic stall_seen,
    input wire logic [PHASES-1:0] phase_cmd,
    // bank outputs
    input wire logic hall_comparator_hysteresis,
    input wire logic rotation_ccw,
    input wire logic bridge_brake,
    input wire logic bridge_coast,
    input wire logic [2:0] phase_lead_angle,
    input wire logic speed_pulse_output,
    input wire logic stall_fault,
    input wire logic drive_inhibit,
    input wire logic [PHASES-1:0] phase_drive
);
    // register shadows; live_q keeps $past off reset values
    logic [7:0] stall_q;
    logic dly_en_q;
    logic [1:0] live_q;

    function automatic logic [7:0] wmask(input logic [5:0] a);
        case (a)
            OFS_HALL_BRAKE_DIRECTION_CTRL: wmask = WMASK_HALL_BRAKE_DIRECTION_CTRL;
            OFS_SPEED_PULSE_STALL_CTRL: wmask = WMASK_SPEED_PULSE_STALL_CTRL;
            OFS_PHASE_LEAD_CTRL: wmask = WMASK_PHASE_LEAD_CTRL;
            OFS_DELAY_MATCH_CTRL: wmask = WMASK_DELAY_MATCH_CTRL;
            default: wmask = 8'h00;
        endcase
    endfunction

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stall_q <= RST_SPEED_PULSE_STALL_CTRL;
            dly_en_q <= 1'b0;
            live_q <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == OFS_SPEED_PULSE_STALL_CTRL) begin
                stall_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == OFS_DELAY_MATCH_CTRL) begin
                dly_en_q <= reg_wdata[POS_DLY_EN];
            end
            if (live_q != 2'h3) begin
                live_q <= live_q + 2'h1;
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_READ_UNMAPPED: assert property (reg_rd && wmask(reg_addr) == 8'h00
        |=> reg_rvalid && reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_READ_RESERVED: assert property (reg_rd
        |=> reg_rvalid && (reg_rdata & ~wmask($past(reg_addr))) == 8'h00)
        else $error("reserved bits read nonzero");
    AST_DIR_WRITE: assert property (reg_wr && reg_addr == OFS_HALL_BRAKE_DIRECTION_CTRL
        |=> rotation_ccw == $past(reg_wdata[POS_ROTATION])) else $error("direction lost");
    AST_HYS_WRITE: assert property (reg_wr && reg_addr == OFS_HALL_BRAKE_DIRECTION_CTRL
        |=> hall_comparator_hysteresis == $past(reg_wdata[POS_HALL_COMPARATOR_HYSTERESIS]))
        else $error("hysteresis lost");
    AST_LEAD_WRITE: assert property (reg_wr && reg_addr == OFS_PHASE_LEAD_CTRL
        |=> phase_lead_angle == $past(reg_wdata[2:0])) else $error("phase lead lost");
    AST_BRAKE_COAST_EXCL: assert property (!(bridge_brake && bridge_coast))
        else $error("brake and coast together");
    AST_FAULT_CAUSE: assert property ($rose(stall_fault)
        |-> $past(stall_seen) && stall_q[1:0] != 2'h3) else $error("fault without stall");
    AST_REPORT_NO_INHIBIT: assert property ($rose(drive_inhibit)
        |-> !stall_q[1] && stall_fault) else $error("inhibit in report mode");
    AST_SPEED_DIV_ONE: assert property (live_q == 2'h3 && stall_q[7:6] == 2'h0
        && $past(stall_q[7:6]) == 2'h0 |-> speed_pulse_output == $past(comm_level))
        else $error("speed pulse not following");
    AST_DLY_OFF_PASS: assert property (live_q == 2'h3 && !dly_en_q && !$past(dly_en_q)
        |-> phase_drive == $past(phase_cmd)) else $error("phase drive not following");
endmodule

bind mdc_ctrl_regs mdc_ctrl_regs_chk #(.PHASES(PHASES)) mdc_ctrl_regs_chk_inst (.*);
`default_nettype wire

// file: verif/mdc_motor_model.sv
// partner model: a three-phase motor whose hall edges give the commutation wave
// assumes the bench sets run, locked and half at the falling edge
`timescale 1ns/1ps
`default_nettype none
module mdc_motor_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // mechanical state
    input wire logic run,
    input wire logic locked,
    input wire logic [7:0] half,
    // hall-derived signals
    output logic comm_level,
    output logic stall_seen
);
    logic [7:0] cnt;
    // a locked rotor stops commutation; falling edge keeps off the sample
    always @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 8'h00;
            comm_level <= 1'b0;
        end else if (run && !locked) begin
            if (cnt + 8'h01 >= half) begin
                cnt <= 8'h00;
                comm_level <= !comm_level;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
    assign stall_seen = run && locked;
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for mdc_ctrl_regs with a motor model on the far side
// assumes one cycle per millisecond
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mdc_pkg::*;
    localparam int MS = 1;
    localparam int SRC = 2;
    localparam int SNK = 4;
    logic ref_clk, rstn, wr_s, rd_s, clr, run, locked, rv, comm, stl;
    logic hys, ccw, brk, cst, spd, flt, inh;
    logic [5:0] addr;
    logic [7:0] wd, rdat, half, v;
    logic [2:0] lead, pcmd, psrc, pdrv;
    logic [7:0] rst_tab [4] = '{8'h01, 8'h41, 8'h00, 8'h00};
    int det_tab [4] = '{300, 500, 1000, 5000};
    int failures, compares;

    mdc_ctrl_regs #(.CYC_PER_MS_P(MS), .SRC_DLY_CYC(SRC), .SNK_DLY_CYC(SNK)) mdc_ctrl_regs_inst (
        .ref_clk(ref_clk), .rstn(rstn), .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr),
        .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .comm_level(comm),
        .stall_seen(stl), .stall_clear(clr), .phase_cmd(pcmd), .phase_sourcing(psrc),
        .hall_comparator_hysteresis(hys), .rotation_ccw(ccw), .bridge_brake(brk),
        .bridge_coast(cst), .phase_lead_angle(lead), .speed_pulse_output(spd),
        .stall_fault(flt), .drive_inhibit(inh), .phase_drive(pdrv));
    mdc_motor_model mdc_motor_model_inst (.ref_clk(ref_clk), .rstn(rstn), .run(run),
        .locked(locked), .half(half), .comm_level(comm), .stall_seen(stl));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wr_s = 1'b1; addr = a; wd = d;
        cyc(1);
        wr_s = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        rd_s = 1'b1; addr = a;
        cyc(1);
        rd_s = 1'b0;
        chk("read answer", 1, rv);
        d = rdat;
        cyc(1);
    endtask
    function automatic logic [7:0] exp_rd(input logic [5:0] a, input logic [7:0] d);
        return d & ((a == 6'h09 || a == 6'h0C) ? 8'h1F : (a == 6'h0A) ? 8'hDF
            : (a == 6'h0B) ? 8'h07 : 8'h00);
    endfunction
    function automatic int exp_lat(input logic en, input logic [3:0] g, input logic s);
        int w;
        w = (g == 4'h0) ? 0 : (int'(g) + 1) * 5 - (s ? SRC : SNK);
        return (en && w > 0) ? 1 + w : 1;
    endfunction
    task automatic count_spd(output int n_out);
        logic ps;
        n_out = 0;
        ps = spd;
        repeat (64 * int'(half)) begin
            cyc(1);
            if (spd && !ps) n_out++;
            ps = spd;
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #(40 * 60000);
        failures++;
        give_verdict();
    end

    initial begin
        int n;
        logic [3:0] g;
        logic [5:0] a;
        logic s, en;
        rstn = 1'b0; wr_s = 1'b0; rd_s = 1'b0; clr = 1'b0; run = 1'b0; locked = 1'b0;
        addr = 6'h00; wd = 8'h00; half = 8'h03; pcmd = 3'h0; psrc = 3'h0;
        failures = 0; compares = 0;
        void'($urandom(19997));
        cyc(2);
        rstn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(6'(9 + i), v);
            chk("reset value", rst_tab[i], v);
        end
        chk("reset outputs", 16'h0001, {hys, brk, cst, lead, ccw});
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 6'h0A : (i == 1) ? 6'h3F : 6'(8 + $urandom_range(5));
            wd = (i == 0) ? 8'hFF : 8'($urandom);
            v = wd;
            wr(a, v);
            rd(a, wd);
            chk("readback", exp_rd(a, v), wd);
            if (a == 6'h09) chk("dir hys", {v[4], v[0]}, {hys, ccw});
            if (a == 6'h0B) chk("lead", v[2:0], lead);
        end
        $display("test registers done");
        for (int b = 0; b < 8; b++) begin
            wr(6'h09, {4'h0, 3'(b), 1'b1});
            cyc(2);
            chk("bridge", {b[0] & !b[1] & !b[2], b[1] | (b[2] & b[0])}, {brk, cst});
        end
        $display("test bridge done");
        run = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(6'h0A, {2'(c), 6'h01});
            count_spd(n);
            count_spd(n);
            chk("speed pulses", 32 >> c, n);
        end
        $display("test speed done");
        for (int m = 0; m < 4; m++) begin
            wr(6'h0A, {2'h1, 1'b0, 1'(m == 1), 2'(m), 2'(m)});
            locked = 1'b1;
            cyc(det_tab[m] * MS - 1);
            chk("early fault", 0, flt);
            cyc(2);
            chk("fault", m < 3, flt);
            chk("inhibit", m < 2, inh);
            locked = 1'b0;
            if (m == 1) begin
                cyc(5000 * MS - 2);
                chk("retry hold", 1, inh);
                cyc(4);
                chk("retry end", 0, {flt, inh});
            end else begin
                cyc(40);
                chk("fault kept", m < 3, flt);
                clr = 1'b1;
                cyc(1);
                clr = 1'b0;
                cyc(3);
                chk("cleared", 0, {flt, inh});
            end
        end
        $display("test stall done");
        for (int i = 0; i < 10; i++) begin
            g = (i < 3) ? 4'(i * 15) : 4'($urandom);
            s = 1'($urandom_range(1));
            en = (i != 1);
            wr(6'h0C, {3'h0, en, g});
            psrc = {3{s}};
            pcmd = ~pcmd;
            n = 0;
            while (pdrv !== pcmd && n < 100) begin cyc(1); n++; end
            chk("delay", exp_lat(en, g, s), n);
            cyc(2);
        end
        $display("test delay done");
        give_verdict();
    end
endmodule
`default_nettype wire
